/* pkg/ccs_pkg.sv */
// Package for the conversion cycle sequencer and serial readout block
package ccs_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] CCS_OFS_CTRL = 8'h00;
  localparam logic [7:0] CCS_OFS_STATUS = 8'h04;
  localparam logic [7:0] CCS_OFS_MASK = 8'h08;
  localparam logic [7:0] CCS_OFS_RESULT = 8'h0c;

  // Control register field positions
  localparam int CCS_CTRL_ACQ_LSB = 0;
  localparam int CCS_CTRL_PPR_LSB = 2;
  localparam int CCS_CTRL_TC_BIT = 6;
  localparam int CCS_CTRL_RUN_BIT = 7;

  // Status and mask bit positions
  localparam int CCS_ST_DONE = 0;
  localparam int CCS_ST_OVERRUN = 1;
  localparam int CCS_ST_LATE_START = 2;
  localparam int CCS_ST_W = 3;

  // Reset values
  localparam logic [7:0] CCS_CTRL_RST = 8'h00;
  localparam logic [2:0] CCS_MASK_RST = 3'h0;

  // Acquisition length codes, one reset clock included
  localparam logic [1:0] CCS_ACQ_OFF = 2'h0;
  localparam logic [5:0] CCS_ACQ_LEN_00 = 6'h01;
  localparam logic [5:0] CCS_ACQ_LEN_01 = 6'h01;
  localparam logic [5:0] CCS_ACQ_LEN_10 = 6'h10;
  localparam logic [5:0] CCS_ACQ_LEN_11 = 6'h20;

  // Per point reads: code 1xxx selects the largest group
  localparam logic [3:0] CCS_PPR_MAX_SHIFT = 4'h8;

  // Data widths
  localparam int CCS_SAMPLE_W = 20;
  localparam int CCS_WORD_W = 21;
  localparam int CCS_ACC_W = 28;
  localparam logic [4:0] CCS_WORD_LEN = 5'h15;

  // Pin synchroniser indices
  localparam int CCS_PIN_SYSCLK = 0;
  localparam int CCS_PIN_START = 1;
  localparam int CCS_PIN_SCLK = 2;
  localparam int CCS_PIN_SEN = 3;
  localparam int CCS_PIN_CHAIN = 4;
  localparam int CCS_PIN_N = 5;

  // Conversion phases
  typedef enum logic [2:0] {
    CCS_PH_IDLE,
    CCS_PH_ACQ,
    CCS_PH_INIT,
    CCS_PH_TRACK,
    CCS_PH_FINAL
  } ccs_phase_t;

  // Setup word as held in the control register
  typedef struct packed {
    logic run;
    logic twos_comp;
    logic [3:0] ppr_code;
    logic [1:0] acq_code;
  } ccs_setup_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ccs_bus_req_t;

endpackage

/* hdl/ccs_top.sv */
// Conversion cycle sequencer with serial result readout
//
// The register offsets and strobed register access were chosen for this implementation.
module ccs_top
  import ccs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire ccs_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  // Interrupt
  output logic irq,
  // Host pins
  input wire logic sys_clk_in,
  input wire logic final_start_in,
  input wire logic shift_clk_in,
  input wire logic shift_out_enable_in,
  input wire logic chain_serial_in,
  output logic serial_result_out,
  output logic serial_result_oe,
  output logic result_ready_flag,
  // Tracking logic sample stream
  input wire logic [CCS_SAMPLE_W-1:0] sample_in
);

  // Whole state of the block
  typedef struct packed {
    logic [CCS_PIN_N-1:0] s1;
    logic [CCS_PIN_N-1:0] s2;
    logic [CCS_PIN_N-1:0] s3;
    logic [CCS_PIN_N-1:0] lvl;
    ccs_phase_t ph;
    logic [8:0] cnt;
    logic [CCS_ACC_W-1:0] acc;
    logic [CCS_SAMPLE_W-1:0] init_avg;
    logic [CCS_WORD_W-1:0] sr;
    logic [CCS_WORD_W-1:0] last;
    logic [4:0] nshift;
    logic ready;
    logic load;
    ccs_setup_t setup;
    logic [CCS_ST_W-1:0] sts;
    logic [CCS_ST_W-1:0] msk;
    logic irq;
    logic [31:0] rdata;
  } ccs_state_t;

  ccs_state_t q;
  ccs_state_t d;

  // Pin edges, valid once the second and third stages agree
  logic [CCS_PIN_N-1:0] agree;
  logic [CCS_PIN_N-1:0] rise;
  assign agree = ~(q.s2 ^ q.s3);
  assign rise = agree & q.s3 & ~q.lvl;

  logic tick;
  logic start_ev;
  logic shift_ev;
  assign tick = rise[CCS_PIN_SYSCLK];
  assign start_ev = rise[CCS_PIN_START];
  assign shift_ev = rise[CCS_PIN_SCLK] & q.lvl[CCS_PIN_SEN];

  // Setup decode
  logic cds_on;
  logic [3:0] m_sh;
  logic [8:0] m_len;
  logic [5:0] k_len;
  assign cds_on = q.setup.acq_code != CCS_ACQ_OFF;
  assign m_sh = q.setup.ppr_code[3] ? CCS_PPR_MAX_SHIFT : {1'b0, q.setup.ppr_code[2:0]};
  assign m_len = 9'(9'h001 << m_sh);

  // Acquisition length per code; the reset clock is counted in
  always_comb begin
    case (q.setup.acq_code)
      2'h0: k_len = CCS_ACQ_LEN_00;
      2'h1: k_len = CCS_ACQ_LEN_01;
      2'h2: k_len = CCS_ACQ_LEN_10;
      default: k_len = CCS_ACQ_LEN_11;
    endcase
  end

  // Accumulated group sum including the current sample, and its average
  logic [CCS_ACC_W-1:0] sum;
  logic [CCS_ACC_W-1:0] avg_full;
  logic [CCS_SAMPLE_W-1:0] avg;
  logic last_read;
  assign sum = q.acc + CCS_ACC_W'(sample_in);
  assign avg_full = sum >> m_sh;
  assign avg = avg_full[CCS_SAMPLE_W-1:0];
  // Last read of a group lands on the tick that ends the point
  assign last_read = tick && (q.cnt == m_len - 9'h001);

  // Result word in the selected format
  // In two's complement a final point below the initial one goes negative, sign bit leading
  logic [CCS_WORD_W-1:0] diff;
  logic [CCS_WORD_W-1:0] word;
  assign diff = cds_on ? ({1'b0, avg} - {1'b0, q.init_avg}) : {1'b0, avg};
  assign word = q.setup.twos_comp ? diff : {avg, 1'b0};

  logic [CCS_ST_W-1:0] sts_set;
  logic [CCS_ST_W-1:0] sts_clr;

  // Next state
  always_comb begin
    d = q;
    d.load = 1'b0;
    sts_set = '0;
    sts_clr = '0;

    // Three stage pin synchronisers
    for (int i = 0; i < CCS_PIN_N; i++) begin
      if (agree[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
    d.s1 = {chain_serial_in, shift_out_enable_in, shift_clk_in, final_start_in, sys_clk_in};
    d.s2 = q.s1;
    d.s3 = q.s2;

    // Conversion phase sequencer
    case (q.ph)
      CCS_PH_IDLE: begin
        if (q.setup.run) begin
          d.ph = CCS_PH_ACQ;
          d.cnt = '0;
        end
      end
      CCS_PH_ACQ: begin
        if (tick) begin
          if (q.cnt == 9'(k_len - 6'h01)) begin
            d.ph = cds_on ? CCS_PH_INIT : CCS_PH_TRACK;
            d.cnt = '0;
            d.acc = '0;
          end else begin
            d.cnt = q.cnt + 9'h001;
          end
        end
      end
      CCS_PH_INIT: begin
        if (tick) begin
          d.acc = sum;
          d.cnt = q.cnt + 9'h001;
          if (last_read) begin
            d.init_avg = avg;
            d.ph = CCS_PH_TRACK;
          end
        end
      end
      CCS_PH_TRACK: begin
        // Tracking lasts until the host asks for the final point
        if (start_ev) begin
          d.ph = CCS_PH_FINAL;
          d.cnt = '0;
          d.acc = '0;
        end
      end
      CCS_PH_FINAL: begin
        if (tick) begin
          d.acc = sum;
          d.cnt = q.cnt + 9'h001;
          if (last_read) begin
            d.load = 1'b1;
            d.last = word;
            d.ph = CCS_PH_ACQ;
            d.cnt = '0;
          end
        end
      end
      default: d.ph = CCS_PH_IDLE;
    endcase

    // Stopping abandons the cycle except a final point under way
    if (!q.setup.run && q.ph != CCS_PH_FINAL) begin
      d.ph = CCS_PH_IDLE;
    end

    // Start commands outside tracking are dropped and flagged
    if (start_ev && q.ph != CCS_PH_TRACK) begin
      sts_set[CCS_ST_LATE_START] = 1'b1;
    end

    // Serial shift register; a load beats a shift in the same cycle
    if (d.load) begin
      d.sr = word;
      d.nshift = '0;
      d.ready = 1'b1;
      sts_set[CCS_ST_DONE] = 1'b1;
      if (q.nshift != CCS_WORD_LEN) begin
        sts_set[CCS_ST_OVERRUN] = 1'b1;
      end
    end else if (shift_ev) begin
      d.sr = {q.sr[CCS_WORD_W-2:0], q.lvl[CCS_PIN_CHAIN]};
      d.ready = 1'b0;
      // Count saturates, so a fully read word never reports an overrun
      if (q.nshift != CCS_WORD_LEN) begin
        d.nshift = q.nshift + 5'h01;
      end
    end

    // Register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        CCS_OFS_CTRL: d.setup = bus_req.wdata[7:0];
        CCS_OFS_STATUS: sts_clr = bus_req.wdata[CCS_ST_W-1:0];
        CCS_OFS_MASK: d.msk = bus_req.wdata[CCS_ST_W-1:0];
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle
    d.sts = (q.sts & ~sts_clr) | sts_set;
    d.irq = |(d.sts & d.msk);

    // Read data stands only in the cycle after the strobe
    d.rdata = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        CCS_OFS_CTRL: d.rdata = {24'h000000, q.setup};
        CCS_OFS_STATUS: d.rdata = {29'h00000000, q.sts};
        CCS_OFS_MASK: d.rdata = {29'h00000000, q.msk};
        CCS_OFS_RESULT: d.rdata = {11'h000, q.last};
        default: d.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.ph <= CCS_PH_IDLE;
      q.setup <= CCS_CTRL_RST;
      q.msk <= CCS_MASK_RST;
      q.nshift <= CCS_WORD_LEN;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state flip-flops
  assign bus_rdata = q.rdata;
  assign irq = q.irq;
  assign serial_result_out = q.sr[CCS_WORD_W-1];
  assign serial_result_oe = q.lvl[CCS_PIN_SEN];
  assign result_ready_flag = q.ready;

  // Checks
  // A stop written mid-point leaves one stale cycle; acquisition and initial point length checks require run
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_track_start;
    q.setup.run && q.ph == CCS_PH_TRACK && start_ev;
  endsequence

  sequence s_acq_end;
    q.ph == CCS_PH_ACQ && tick && q.cnt == 9'(k_len - 6'h01);
  endsequence

  sequence s_final_end;
    q.ph == CCS_PH_FINAL && last_read;
  endsequence

  chk_oe_follows_en: assert property (
    agree[CCS_PIN_SEN] |=> serial_result_oe == $past(q.s3[CCS_PIN_SEN]))
    else $error("output enable does not follow shift enable");

  chk_result_held: assert property (
    !d.load && !shift_ev |=> $stable(q.sr))
    else $error("shift register changed without load or shift");

  chk_load_word: assert property (
    s_final_end |=> q.sr == $past(word) && result_ready_flag)
    else $error("new result not loaded at conversion end");

  chk_chain_shift: assert property (
    shift_ev && !d.load |=> q.sr[0] == $past(q.lvl[CCS_PIN_CHAIN]))
    else $error("chain bit not shifted in");

  chk_bit_per_clock: assert property (
    shift_ev && !d.load |=> serial_result_out == $past(q.sr[CCS_WORD_W-2]))
    else $error("serial output did not advance by one bit");

  chk_track_to_final: assert property (
    s_track_start |=> q.ph == CCS_PH_FINAL && q.cnt == 9'h000)
    else $error("start command did not open the final point");

  chk_phase_order: assert property (
    q.ph == CCS_PH_FINAL && $past(q.ph) != CCS_PH_FINAL |-> $past(q.ph) == CCS_PH_TRACK)
    else $error("final point entered out of order");

  chk_no_init_off: assert property (
    q.ph == CCS_PH_INIT && $past(q.ph) != CCS_PH_INIT |-> $past(cds_on))
    else $error("initial point taken with correction off");

  chk_reads_pow2: assert property (
    $onehot(m_len) && m_len <= 9'h100)
    else $error("reads per point outside powers of two to 256");

  chk_point_length: assert property (
    q.ph == CCS_PH_FINAL && tick |-> q.cnt < m_len)
    else $error("data point ran longer than its reads");

  chk_sign_first: assert property (
    (s_final_end and q.setup.twos_comp) |=> serial_result_out == $past(diff[CCS_WORD_W-1]))
    else $error("sign bit not presented first");

  chk_acq_length: assert property (
    q.setup.run && q.ph == CCS_PH_ACQ && tick |-> q.cnt < 9'(k_len))
    else $error("acquisition ran longer than its code");

  chk_init_length: assert property (
    q.setup.run && q.ph == CCS_PH_INIT && tick |-> q.cnt < m_len)
    else $error("initial point ran longer than its reads");

  chk_init_skip: assert property (
    (s_acq_end and (!cds_on && q.setup.run)) |=> q.ph == CCS_PH_TRACK)
    else $error("initial point not skipped with correction off");

  chk_acc_cleared: assert property (
    s_track_start |=> q.acc == '0)
    else $error("final point sum not cleared at start");

  chk_idle_on_stop: assert property (
    !q.setup.run && q.ph != CCS_PH_FINAL |=> q.ph == CCS_PH_IDLE)
    else $error("stop did not return the sequencer to idle");

  chk_late_flag: assert property (
    start_ev && q.ph != CCS_PH_TRACK |=> q.sts[CCS_ST_LATE_START])
    else $error("start outside tracking not flagged");

  chk_overrun_flag: assert property (
    d.load && q.nshift != CCS_WORD_LEN |=> q.sts[CCS_ST_OVERRUN])
    else $error("overwrite of an unread result not flagged");

endmodule

/* tb/ccs_host_model.sv */
// Host controller model: system clock, start commands and serial readout
module ccs_host_model (
  // Clock
  input wire logic mclk,
  // Host pins
  output logic sys_clk_in,
  output logic final_start_in,
  output logic shift_clk_in,
  output logic shift_out_enable_in,
  output logic chain_serial_in,
  // Shared serial line
  input wire logic data_line
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] div_q = 4'h0;

  // Pins idle low at time zero
  initial begin
    sys_clk_in = 1'b0;
    final_start_in = 1'b0;
    shift_clk_in = 1'b0;
    shift_out_enable_in = 1'b0;
    chain_serial_in = 1'b0;
  end

  // System clock of 20 mclk; scaled down from nominal so runs stay short
  always @(posedge mclk) begin
    div_q <= (div_q == 4'h9) ? 4'h0 : div_q + 4'h1;
    if (div_q == 4'h9) begin
      sys_clk_in <= ~sys_clk_in;
    end
  end

  // One start command; pulse long enough for the pin synchroniser
  task automatic start_cmd();
    @(posedge mclk);
    final_start_in <= 1'b1;
    repeat (8) @(posedge mclk);
    final_start_in <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  // Output enable level, then settle time for the synchroniser
  task automatic set_enable(input logic en);
    @(posedge mclk);
    shift_out_enable_in <= en;
    repeat (10) @(posedge mclk);
  endtask

  // Whole word MSB first, one sample per shift clock; feeds upstream bits
  task automatic shift_word(input logic [20:0] chain, output logic [20:0] got);
    for (int i = 20; i >= 0; i--) begin
      chain_serial_in <= chain[i];
      repeat (8) @(posedge mclk);
      got[i] = data_line;
      shift_clk_in <= 1'b1;
      repeat (8) @(posedge mclk);
      shift_clk_in <= 1'b0;
    end
  endtask
endmodule

/* tb/ccs_top_test.sv */
// Self-checking bench for the conversion sequencer and serial readout
module ccs_top_test
  import ccs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  ccs_bus_req_t bus_req = '0;
  logic [31:0] bus_rdata;
  logic irq, serial_result_out, serial_result_oe, result_ready_flag;
  logic sys_clk_in, final_start_in, shift_clk_in, shift_out_enable_in, chain_serial_in;
  logic [CCS_SAMPLE_W-1:0] sample_in = '0;
  logic [31:0] rd_v;
  logic [20:0] got;
  int n;
  int error_cnt = 0;
  int n_tests = 0;
  // Shared line floats unless the block drives it
  wire data_line = serial_result_oe ? serial_result_out : 1'bz;

  // 100 MHz clock
  always #5 mclk = ~mclk;

  ccs_top dut (
    .mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .irq(irq),
    .sys_clk_in(sys_clk_in), .final_start_in(final_start_in), .shift_clk_in(shift_clk_in),
    .shift_out_enable_in(shift_out_enable_in), .chain_serial_in(chain_serial_in),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
    .result_ready_flag(result_ready_flag), .sample_in(sample_in)
  );

  ccs_host_model host (
    .mclk(mclk), .sys_clk_in(sys_clk_in), .final_start_in(final_start_in),
    .shift_clk_in(shift_clk_in), .shift_out_enable_in(shift_out_enable_in),
    .chain_serial_in(chain_serial_in), .data_line(data_line)
  );

  // Compare and count
  task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, g, e);
    end
  endtask

  // Register bus cycles
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
    reg_rd(a, rd_v);
    check(rd_v, e, what);
  endtask

  // Bounded wait for the interrupt raised by a result load
  task automatic wait_irq(output int cnt);
    cnt = 0;
    while (irq !== 1'b1 && cnt < 20000) begin
      @(posedge mclk);
      #1;
      cnt++;
    end
    check({31'h0, irq}, 32'h1, "irq after load");
  endtask

  task automatic t_reset();
    check({29'h0, irq, serial_result_oe, result_ready_flag}, 32'h0, "outputs at reset");
    rd_chk(CCS_OFS_CTRL, {24'h0, CCS_CTRL_RST}, "ctrl reset");
    rd_chk(CCS_OFS_STATUS, 32'h0, "status reset");
    rd_chk(CCS_OFS_MASK, {29'h0, CCS_MASK_RST}, "mask reset");
    reg_wr(8'h10, 32'hff);
    rd_chk(8'h10, 32'h0, "unmapped");
    reg_wr(CCS_OFS_MASK, 32'h7);
    rd_chk(CCS_OFS_MASK, 32'h7, "mask rw");
    reg_wr(CCS_OFS_MASK, 32'h1);
  endtask

  // No correction, one read per point, two's complement
  task automatic t_nocds();
    @(posedge mclk);
    sample_in <= 20'h12345;
    reg_wr(CCS_OFS_CTRL, 32'hc0);
    repeat (100) @(posedge mclk);
    host.start_cmd();
    wait_irq(n);
    rd_chk(CCS_OFS_RESULT, 32'h012345, "result no correction");
    reg_rd(CCS_OFS_STATUS, rd_v);
    check({31'h0, rd_v[0]}, 32'h1, "done flag");
    check({31'h0, result_ready_flag}, 32'h1, "ready after load");
    reg_wr(CCS_OFS_STATUS, 32'h7);
    repeat (3) @(posedge mclk);
    check({31'h0, irq}, 32'h0, "irq cleared");
  endtask

  // Correction on, 16 acquisition clocks, 128 reads; early start refused
  task automatic t_cds();
    reg_wr(CCS_OFS_CTRL, 32'h0);
    @(posedge mclk);
    sample_in <= 20'h00100;
    reg_wr(CCS_OFS_CTRL, 32'hde);
    host.start_cmd();
    repeat (3000) @(posedge mclk);
    sample_in <= 20'h00040;
    repeat (100) @(posedge mclk);
    check({31'h0, irq}, 32'h0, "masked status bit");
    host.start_cmd();
    wait_irq(n);
    rd_chk(CCS_OFS_RESULT, 32'h1fff40, "final minus initial");
    rd_chk(CCS_OFS_STATUS, 32'h7, "overrun and early start");
    reg_wr(CCS_OFS_STATUS, 32'h7);
  endtask

  // Three-state output, serial word, then upstream data through the chain
  task automatic t_shift();
    host.set_enable(1'b0);
    check({31'h0, serial_result_oe}, 32'h0, "released when disabled");
    host.set_enable(1'b1);
    check({31'h0, serial_result_oe}, 32'h1, "driven when enabled");
    check({31'h0, result_ready_flag}, 32'h1, "ready before readout");
    host.shift_word(21'h15a5c3, got);
    check({11'h0, got}, 32'h1fff40, "serial word");
    check({31'h0, result_ready_flag}, 32'h0, "ready cleared by shifting");
    host.shift_word(21'h000000, got);
    check({11'h0, got}, 32'h15a5c3, "chained word");
    host.set_enable(1'b0);
    check({31'h0, serial_result_oe}, 32'h0, "released again");
  endtask

  // Largest group, straight binary, correction with no acquisition, final point duration
  task automatic t_m256();
    reg_wr(CCS_OFS_CTRL, 32'h0);
    @(posedge mclk);
    sample_in <= 20'h54321;
    reg_wr(CCS_OFS_CTRL, 32'ha1);
    rd_chk(CCS_OFS_CTRL, 32'ha1, "ctrl rw");
    // Initial point of 256 reads must finish before the start command
    repeat (5300) @(posedge mclk);
    host.start_cmd();
    wait_irq(n);
    check({31'h0, 1'(n >= 5080 && n <= 5160)}, 32'h1, "256 read duration");
    rd_chk(CCS_OFS_RESULT, 32'h0a8642, "straight binary word");
    rd_chk(CCS_OFS_STATUS, 32'h1, "no overrun after full read");
    reg_wr(CCS_OFS_STATUS, 32'h7);
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("Checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog: tests take about 17000 cycles
  initial begin
    repeat (40000) @(posedge mclk);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_nocds();
    t_cds();
    t_shift();
    t_m256();
    complete_run();
  end
endmodule
